// ===== guard_pkg.sv
// Shared constants and types for the sector guard and lock block
package guard_pkg;

	// Sector map
	localparam int unsigned SECTOR_COUNT = 1054;
	localparam int unsigned SECTOR_W = 11;
	typedef logic [SECTOR_W-1:0] sector_t;
	typedef logic [7:0] byte_t;
	typedef logic [SECTOR_COUNT-1:0] guard_vec_t;
	localparam sector_t SECTOR_LIMIT = sector_t'(SECTOR_COUNT);

	// Command opcodes
	localparam byte_t OP_LOCK_READ = 8'hA7;
	localparam byte_t OP_LOCK_CLEAR = 8'hA6;
	localparam byte_t OP_LATCH_SET = 8'h91;
	localparam byte_t OP_NV_PROG = 8'hFD;
	localparam byte_t OP_NV_PROG_LONG = 8'hE3;
	localparam byte_t OP_NV_ERASE = 8'hE4;
	localparam byte_t OP_NV_READ = 8'hFC;
	localparam byte_t OP_NV_READ_LONG = 8'hE2;
	localparam byte_t OP_V_WRITE = 8'hFB;
	localparam byte_t OP_V_WRITE_LONG = 8'hE1;
	localparam byte_t OP_V_READ = 8'hFA;
	localparam byte_t OP_V_READ_LONG = 8'hE0;
	localparam byte_t OP_PAT_READ = 8'h41;
	localparam byte_t OP_PAT_STORE = 8'h43;
	localparam byte_t OP_PAT_WRITE = 8'h4A;

	// Lock register layout
	localparam int unsigned LOCK_BIT_POS = 0;
	localparam int unsigned LATCH_BIT_POS = 7;

	// Values and reset states
	localparam byte_t GUARD_ON = 8'h00;
	localparam byte_t GUARD_OFF = 8'hFF;
	localparam byte_t PATTERN_RESET = 8'h00;
	localparam byte_t BYTE_ZERO = 8'h00;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic LATCH_RESET = 1'b0;
	localparam logic INIT_RESET = 1'b1;
	localparam guard_vec_t GUARD_ALL_OFF = '1;

	// Protection mode bits
	localparam logic [1:0] MODE_PASSWORD = 2'h1;

	// Configuration targets frozen by the latch
	typedef enum logic [1:0] {
		CFG_BLOCK_PROTECT = 2'b00,
		CFG_TOP_BOTTOM = 2'b01,
		CFG_PARAM_LOC = 2'b10,
		CFG_INFO_ROW = 2'b11
	} cfg_target_e;

	// Decoded command from the serial front end
	typedef struct packed {
		byte_t opcode;
		sector_t sector;
		byte_t data;
	} cmd_s;

	// Read answer
	typedef struct packed {
		logic valid;
		byte_t data;
	} rsp_s;

endpackage : guard_pkg

// ===== host_model.sv
// Host command model that issues one flash command at a time
module host_model (
	// Clock
	input wire logic clock,
	// Device answers
	input wire guard_pkg::rsp_s rsp,
	input wire logic cmd_refused,
	// Command towards the device
	output logic cmd_valid,
	output guard_pkg::cmd_s cmd
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle command port at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// Drive one command, sample its answer after the taking edge
	task automatic send(input guard_pkg::byte_t op, input guard_pkg::sector_t sec,
		input guard_pkg::byte_t dat, output guard_pkg::rsp_s ans, output logic refused);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd = '{opcode: op, sector: sec, data: dat};
		@(negedge clock);
		ans = rsp;
		refused = cmd_refused;
		cmd_valid = 1'b0;
		cmd = ~cmd; // Released port shows no stale command
	endtask : send
endmodule : host_model

// ===== nv_guard_store.sv
// Non-volatile sector guard array and stored training pattern
module nv_guard_store (
	// Clock and factory blank state
	input wire logic clock,
	input wire logic nv_blank_n,
	// Update strobes
	input wire logic prog_en,
	input wire guard_pkg::sector_t prog_sector,
	input wire logic erase_en,
	input wire logic pat_store_en,
	input wire guard_pkg::byte_t pat_data,
	// Stored contents
	output guard_pkg::guard_vec_t nv_guard,
	output guard_pkg::byte_t stored_pattern
);
	guard_pkg::guard_vec_t guard_q;
	guard_pkg::guard_vec_t guard_d;
	guard_pkg::byte_t pat_q;
	guard_pkg::byte_t pat_d;

	// Per-sector next state: erase sets all, program clears one
	generate
		for (genvar i = 0; i < guard_pkg::SECTOR_COUNT; i++) begin : g_nv
			assign guard_d[i] = erase_en ? 1'b1 :
				((prog_en && prog_sector == guard_pkg::sector_t'(i)) ? 1'b0 : guard_q[i]);
		end
	endgenerate

	// Pattern next state
	always_comb begin
		pat_d = pat_store_en ? pat_data : pat_q;
	end

	// Cells survive device resets; only the blank state clears them
	always_ff @(posedge clock or negedge nv_blank_n) begin
		if (!nv_blank_n) begin
			guard_q <= guard_pkg::GUARD_ALL_OFF;
			pat_q <= guard_pkg::PATTERN_RESET;
		end else begin
			guard_q <= guard_d;
			pat_q <= pat_d;
		end
	end

	assign nv_guard = guard_q;
	assign stored_pattern = pat_q;

endmodule : nv_guard_store

// ===== sector_protect_lock_regs.sv
// Sector guard lock, configuration latch, guard bits and training pattern
// Operation
// - Lock bit zero blocks nonvolatile guard changes
// - A6h clears lock unless a password match sets it that cycle; A7h reads lock register
// - Persistent mode sets lock at reset
// - Persistent mode: no command sets lock again
// - Password mode clears lock; unlock sets it
// - Latch set refuses config and info-row writes
// - Latch clears only by power or hardware reset
// - Software reset leaves latch unchanged
// - Latch zero at power-on; 91h sets it
// - FDh/E3h program, E4h erase, FCh/E2h read
// - Nonvolatile read: 00h protecting, FFh erased
// - FBh/E1h write, FAh/E0h read volatile guard
// - Volatile 00h protects, FFh unprotects, default FFh
// - 41h reads, 43h stores, 4Ah writes pattern
// - Live pattern loaded from stored at power-up
// - Training drives the live pattern copy
// - Pattern offered during double-rate dummy cycles
// - Either guard bit zero protects sector
// - Mode bits: 10 persistent, 01 password, 11 persistent
// - Password match sets lock in password mode
module sector_protect_lock_regs (
	// Clock and power-on or hardware reset
	input wire logic clock,
	input wire logic reset_n,
	// Factory blank state of the nonvolatile cells
	input wire logic nv_blank_n,
	// Software reset pulse
	input wire logic sw_reset,
	// Protection mode bits from the configuration register
	input wire logic [1:0] mode_bits,
	// Decoded command
	input wire logic cmd_valid,
	input wire guard_pkg::cmd_s cmd,
	// Password compare result
	input wire logic pwd_match,
	// Read answer and refusal
	output guard_pkg::rsp_s rsp,
	output logic cmd_refused,
	// Configuration write gating
	input wire logic cfg_req_valid,
	input wire guard_pkg::cfg_target_e cfg_target,
	output logic cfg_grant,
	output logic cfg_refuse,
	// Main array program or erase gating
	input wire logic arr_req_valid,
	input wire guard_pkg::sector_t arr_sector,
	output logic arr_grant,
	output logic arr_refuse,
	// Training pattern
	input wire logic train_phase,
	output logic train_drive,
	output guard_pkg::byte_t train_data,
	// Status
	output logic guard_array_lock,
	output logic config_latch
);
	// Control state
	logic init_q, init_d;
	logic lock_q, lock_d;
	logic latch_q, latch_d;
	guard_pkg::byte_t live_q, live_d;
	guard_pkg::guard_vec_t v_guard_q, v_guard_d;
	// Output flops
	guard_pkg::rsp_s rsp_q, rsp_d;
	logic refused_q, refused_d;
	logic cfg_grant_q, cfg_grant_d, cfg_refuse_q, cfg_refuse_d;
	logic arr_grant_q, arr_grant_d, arr_refuse_q, arr_refuse_d;
	logic train_drive_q, train_drive_d;
	guard_pkg::byte_t train_data_q, train_data_d;
	// Decode
	logic take, persist, cmd_in_range, arr_in_range;
	logic is_lock_read, is_lock_clear, is_latch_set;
	logic is_nv_prog, is_nv_erase, is_nv_read;
	logic is_v_write, is_v_read, is_pat_read, is_pat_store, is_pat_write;
	logic nv_prog_en, nv_erase_en, pat_store_en, v_write_en, arr_protected;
	guard_pkg::guard_vec_t nv_guard;
	guard_pkg::byte_t stored_pattern;

	// Mode select: only 01 picks password, all else persistent
	assign persist = (mode_bits != guard_pkg::MODE_PASSWORD);
	assign take = cmd_valid && !init_q;
	assign cmd_in_range = (cmd.sector < guard_pkg::SECTOR_LIMIT);
	assign arr_in_range = (arr_sector < guard_pkg::SECTOR_LIMIT);

	// Opcode decode
	always_comb begin
		is_lock_read = 1'b0;
		is_lock_clear = 1'b0;
		is_latch_set = 1'b0;
		is_nv_prog = 1'b0;
		is_nv_erase = 1'b0;
		is_nv_read = 1'b0;
		is_v_write = 1'b0;
		is_v_read = 1'b0;
		is_pat_read = 1'b0;
		is_pat_store = 1'b0;
		is_pat_write = 1'b0;
		case (cmd.opcode)
			guard_pkg::OP_LOCK_READ: is_lock_read = 1'b1;
			guard_pkg::OP_LOCK_CLEAR: is_lock_clear = 1'b1;
			guard_pkg::OP_LATCH_SET: is_latch_set = 1'b1;
			guard_pkg::OP_NV_PROG, guard_pkg::OP_NV_PROG_LONG: is_nv_prog = 1'b1;
			guard_pkg::OP_NV_ERASE: is_nv_erase = 1'b1;
			guard_pkg::OP_NV_READ, guard_pkg::OP_NV_READ_LONG: is_nv_read = 1'b1;
			guard_pkg::OP_V_WRITE, guard_pkg::OP_V_WRITE_LONG: is_v_write = 1'b1;
			guard_pkg::OP_V_READ, guard_pkg::OP_V_READ_LONG: is_v_read = 1'b1;
			guard_pkg::OP_PAT_READ: is_pat_read = 1'b1;
			guard_pkg::OP_PAT_STORE: is_pat_store = 1'b1;
			guard_pkg::OP_PAT_WRITE: is_pat_write = 1'b1;
			default: is_lock_read = 1'b0;
		endcase
	end

	// Nonvolatile guard updates only while the lock bit permits them; pattern store is not gated
	assign nv_prog_en = take && is_nv_prog && cmd_in_range && lock_q;
	assign nv_erase_en = take && is_nv_erase && lock_q;
	assign pat_store_en = take && is_pat_store;
	assign v_write_en = take && is_v_write && cmd_in_range;

	nv_guard_store u_nv_store (
		.clock(clock),
		.nv_blank_n(nv_blank_n),
		.prog_en(nv_prog_en),
		.prog_sector(cmd.sector),
		.erase_en(nv_erase_en),
		.pat_store_en(pat_store_en),
		.pat_data(cmd.data),
		.nv_guard(nv_guard),
		.stored_pattern(stored_pattern)
	);

	// Volatile guard bits: 00h clears, other values set, sw reset unprotects
	generate
		for (genvar i = 0; i < guard_pkg::SECTOR_COUNT; i++) begin : g_vol
			assign v_guard_d[i] = sw_reset ? 1'b1 :
				((v_write_en && cmd.sector == guard_pkg::sector_t'(i)) ?
				(cmd.data != guard_pkg::GUARD_ON) : v_guard_q[i]);
		end
	endgenerate

	// Either guard bit at zero protects the sector
	assign arr_protected = arr_in_range && (!nv_guard[arr_sector] || !v_guard_q[arr_sector]);

	// Lock, latch and live pattern next state
	always_comb begin
		init_d = 1'b0;
		lock_d = lock_q;
		latch_d = latch_q;
		live_d = live_q;
		if (init_q) begin
			lock_d = persist;
			live_d = stored_pattern;
		end else begin
			if (take && is_lock_clear) begin
				lock_d = 1'b0;
			end
			if (pwd_match && !persist) begin
				lock_d = 1'b1;
			end
			if (take && is_latch_set) begin
				latch_d = 1'b1;
			end
			if (sw_reset) begin
				live_d = stored_pattern;
			end else if (take && is_pat_write) begin
				live_d = cmd.data;
			end
		end
	end

	// Answers, refusals and gating outputs
	always_comb begin
		rsp_d.valid = take && (is_lock_read || is_nv_read || is_v_read || is_pat_read);
		rsp_d.data = guard_pkg::BYTE_ZERO;
		if (is_lock_read) begin
			rsp_d.data[guard_pkg::LOCK_BIT_POS] = lock_q;
			rsp_d.data[guard_pkg::LATCH_BIT_POS] = latch_q;
		end else if (is_nv_read) begin
			rsp_d.data = (cmd_in_range && !nv_guard[cmd.sector]) ?
				guard_pkg::GUARD_ON : guard_pkg::GUARD_OFF;
		end else if (is_v_read) begin
			rsp_d.data = (cmd_in_range && !v_guard_q[cmd.sector]) ?
				guard_pkg::GUARD_ON : guard_pkg::GUARD_OFF;
		end else if (is_pat_read) begin
			rsp_d.data = live_q;
		end
		refused_d = take && (is_nv_prog || is_nv_erase) && !lock_q;
		cfg_grant_d = cfg_req_valid && !latch_q;
		cfg_refuse_d = cfg_req_valid && latch_q;
		arr_grant_d = arr_req_valid && !arr_protected;
		arr_refuse_d = arr_req_valid && arr_protected;
		train_drive_d = train_phase;
		train_data_d = live_q;
	end

	// Registers; latch ignores software reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			init_q <= guard_pkg::INIT_RESET;
			lock_q <= guard_pkg::LOCK_RESET;
			latch_q <= guard_pkg::LATCH_RESET;
			live_q <= guard_pkg::PATTERN_RESET;
			v_guard_q <= guard_pkg::GUARD_ALL_OFF;
			rsp_q <= '0;
			refused_q <= 1'b0;
			cfg_grant_q <= 1'b0;
			cfg_refuse_q <= 1'b0;
			arr_grant_q <= 1'b0;
			arr_refuse_q <= 1'b0;
			train_drive_q <= 1'b0;
			train_data_q <= guard_pkg::PATTERN_RESET;
		end else begin
			init_q <= init_d;
			lock_q <= lock_d;
			latch_q <= latch_d;
			live_q <= live_d;
			v_guard_q <= v_guard_d;
			rsp_q <= rsp_d;
			refused_q <= refused_d;
			cfg_grant_q <= cfg_grant_d;
			cfg_refuse_q <= cfg_refuse_d;
			arr_grant_q <= arr_grant_d;
			arr_refuse_q <= arr_refuse_d;
			train_drive_q <= train_drive_d;
			train_data_q <= train_data_d;
		end
	end

	// Output drive
	assign rsp = rsp_q;
	assign cmd_refused = refused_q;
	assign cfg_grant = cfg_grant_q;
	assign cfg_refuse = cfg_refuse_q;
	assign arr_grant = arr_grant_q;
	assign arr_refuse = arr_refuse_q;
	assign train_drive = train_drive_q;
	assign train_data = train_data_q;
	assign guard_array_lock = lock_q;
	assign config_latch = latch_q;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	property p_lock_clear;
		take && is_lock_clear && !pwd_match |=> !guard_array_lock;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared");

	property p_lock_init_persist;
		init_q && persist |=> guard_array_lock;
	endproperty
	a_lock_init_persist: assert property (p_lock_init_persist) else $error("lock not set");

	property p_lock_stays_clear;
		!init_q && persist && !guard_array_lock |=> !guard_array_lock;
	endproperty
	a_lock_stays_clear: assert property (p_lock_stays_clear) else $error("lock reset");

	property p_lock_init_password;
		init_q && !persist |=> !guard_array_lock;
	endproperty
	a_lock_init_password: assert property (p_lock_init_password) else $error("lock set");

	property p_pwd_unlock;
		!init_q && !persist && pwd_match |=> guard_array_lock;
	endproperty
	a_pwd_unlock: assert property (p_pwd_unlock) else $error("unlock failed");

	property p_latch_sticky;
		config_latch |=> config_latch [*2];
	endproperty
	a_latch_sticky: assert property (p_latch_sticky) else $error("latch cleared");

	property p_latch_set;
		take && is_latch_set |=> config_latch;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch not set");

	property p_cfg_refuse;
		cfg_req_valid && config_latch |=> cfg_refuse && !cfg_grant;
	endproperty
	a_cfg_refuse: assert property (p_cfg_refuse) else $error("config not refused");

	property p_nv_locked;
		take && (is_nv_prog || is_nv_erase) && !guard_array_lock |=> cmd_refused && $stable(nv_guard);
	endproperty
	a_nv_locked: assert property (p_nv_locked) else $error("guard changed");

	property p_arr_protect;
		arr_req_valid && arr_protected |=> arr_refuse && !arr_grant;
	endproperty
	a_arr_protect: assert property (p_arr_protect) else $error("sector not protected");

	property p_lock_read;
		take && is_lock_read |=> rsp.valid && rsp.data[6:1] == 6'h00
			&& rsp.data[0] == $past(guard_array_lock);
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("bad lock read");

	property p_train;
		train_phase |=> train_drive && train_data == $past(live_q);
	endproperty
	a_train: assert property (p_train) else $error("bad training data");

endmodule : sector_protect_lock_regs

// ===== test_sector_protect_lock_regs.sv
// Self-checking bench for the sector guard and lock block
module test_sector_protect_lock_regs;
	timeunit 1ns;
	timeprecision 1ns;

	// Design connections
	logic clock = 1'b0;
	logic reset_n, nv_blank_n, sw_reset, cmd_valid, pwd_match, cfg_req_valid;
	logic arr_req_valid, train_phase, cmd_refused, cfg_grant, cfg_refuse;
	logic arr_grant, arr_refuse, train_drive, guard_array_lock, config_latch;
	logic [1:0] mode_bits;
	guard_pkg::cmd_s cmd;
	guard_pkg::rsp_s rsp;
	guard_pkg::cfg_target_e cfg_target;
	guard_pkg::sector_t arr_sector, s1, s2, s3;
	guard_pkg::byte_t train_data, p, q;
	// Bench state
	int mismatches = 0;
	int checks = 0;
	logic [31:0] seed = 32'hBBB98E5B;
	logic [1:0] modes [4] = '{2'h2, 2'h3, 2'h0, 2'h1};

	always #50 clock = ~clock;

	sector_protect_lock_regs DUT (.clock(clock), .reset_n(reset_n), .nv_blank_n(nv_blank_n),
		.sw_reset(sw_reset), .mode_bits(mode_bits), .cmd_valid(cmd_valid), .cmd(cmd),
		.pwd_match(pwd_match), .rsp(rsp), .cmd_refused(cmd_refused),
		.cfg_req_valid(cfg_req_valid), .cfg_target(cfg_target), .cfg_grant(cfg_grant),
		.cfg_refuse(cfg_refuse), .arr_req_valid(arr_req_valid), .arr_sector(arr_sector),
		.arr_grant(arr_grant), .arr_refuse(arr_refuse), .train_phase(train_phase),
		.train_drive(train_drive), .train_data(train_data),
		.guard_array_lock(guard_array_lock), .config_latch(config_latch));

	host_model host (.clock(clock), .rsp(rsp), .cmd_refused(cmd_refused),
		.cmd_valid(cmd_valid), .cmd(cmd));

	// Expectation helpers
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	function automatic guard_pkg::sector_t next(input guard_pkg::sector_t s);
		return (s == guard_pkg::SECTOR_LIMIT - 11'h001) ? 11'h000 : s + 11'h001;
	endfunction : next
	function automatic guard_pkg::byte_t lock_byte(input logic latch, input logic lock);
		return {latch, 6'h00, lock};
	endfunction : lock_byte

	// Comparisons
	task automatic check8(input guard_pkg::byte_t got, input guard_pkg::byte_t exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic check1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check1

	// Command, gating and strobe drivers
	task automatic rd(input guard_pkg::byte_t op, input guard_pkg::sector_t s,
		input guard_pkg::byte_t exp);
		guard_pkg::rsp_s a;
		logic r;
		host.send(op, s, 8'h00, a, r);
		check1(a.valid, 1'b1);
		check8(a.data, exp);
	endtask : rd
	task automatic wr(input guard_pkg::byte_t op, input guard_pkg::sector_t s,
		input guard_pkg::byte_t d, input logic exp_ref);
		guard_pkg::rsp_s a;
		logic r;
		host.send(op, s, d, a, r);
		check1(r, exp_ref);
		check1(a.valid, 1'b0);
	endtask : wr
	task automatic gate_arr(input guard_pkg::sector_t s, input logic exp_ref);
		@(negedge clock);
		arr_req_valid = 1'b1;
		arr_sector = s;
		@(negedge clock);
		check1(arr_refuse, exp_ref);
		check1(arr_grant, !exp_ref);
		arr_req_valid = 1'b0;
		arr_sector = ~s;
	endtask : gate_arr
	task automatic gate_cfg(input int t, input logic exp_ref);
		@(negedge clock);
		cfg_req_valid = 1'b1;
		cfg_target = guard_pkg::cfg_target_e'(t);
		@(negedge clock);
		check1(cfg_refuse, exp_ref);
		check1(cfg_grant, !exp_ref);
		cfg_req_valid = 1'b0;
	endtask : gate_cfg
	task automatic strobe(input logic sw);
		@(negedge clock);
		sw_reset = sw;
		pwd_match = !sw;
		@(negedge clock);
		sw_reset = 1'b0;
		pwd_match = 1'b0;
	endtask : strobe
	task automatic hw_reset(input logic [1:0] m);
		@(negedge clock);
		reset_n = 1'b0;
		mode_bits = m;
		@(negedge clock);
		reset_n = 1'b1;
		repeat (2) @(negedge clock);
	endtask : hw_reset

	// Verdict and end of run
	task automatic report_and_stop;
		$display("Counts: %0d checks, %0d mismatches", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Watchdog against a hang
	initial begin
		#(5000 * 100);
		mismatches++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{reset_n, nv_blank_n, sw_reset, pwd_match, cfg_req_valid} = '0;
		{arr_req_valid, train_phase} = '0;
		mode_bits = 2'h2;
		cfg_target = guard_pkg::CFG_BLOCK_PROTECT;
		arr_sector = '0;
		repeat (8) @(negedge clock);
		nv_blank_n = 1'b1;
		reset_n = 1'b1;
		@(negedge clock);
		seed = xorshift(seed);
		s1 = guard_pkg::sector_t'(seed % guard_pkg::SECTOR_COUNT);
		s2 = next(s1);
		s3 = next(s2);
		check1(guard_array_lock, 1'b1);
		check1(config_latch, 1'b0);
		rd(guard_pkg::OP_LOCK_READ, s1, lock_byte(1'b0, 1'b1));
		rd(guard_pkg::OP_NV_READ, s1, 8'hFF);
		rd(guard_pkg::OP_V_READ, s1, 8'hFF);
		rd(guard_pkg::OP_NV_READ_LONG, guard_pkg::SECTOR_LIMIT, 8'hFF);
		$display("Test reset_values done");
		wr(guard_pkg::OP_NV_PROG, s1, 8'h00, 1'b0);
		wr(guard_pkg::OP_NV_PROG_LONG, s2, 8'h00, 1'b0);
		rd(guard_pkg::OP_NV_READ, s1, 8'h00);
		rd(guard_pkg::OP_NV_READ_LONG, s2, 8'h00);
		gate_arr(s1, 1'b1);
		gate_arr(s3, 1'b0);
		wr(guard_pkg::OP_NV_ERASE, s1, 8'h00, 1'b0);
		rd(guard_pkg::OP_NV_READ_LONG, s2, 8'hFF);
		gate_arr(s1, 1'b0);
		$display("Test nv_guard done");
		seed = xorshift(seed);
		wr(guard_pkg::OP_V_WRITE, s1, 8'h00, 1'b0);
		rd(guard_pkg::OP_V_READ, s1, 8'h00);
		gate_arr(s1, 1'b1);
		wr(guard_pkg::OP_V_WRITE_LONG, s1, seed[7:0] | 8'h01, 1'b0);
		rd(guard_pkg::OP_V_READ_LONG, s1, 8'hFF);
		wr(guard_pkg::OP_V_WRITE_LONG, s2, 8'h00, 1'b0);
		strobe(1'b1);
		rd(guard_pkg::OP_V_READ, s2, 8'hFF);
		$display("Test v_guard done");
		seed = xorshift(seed);
		p = seed[15:8];
		q = ~p | 8'h01; // Never zero and never equal to p
		wr(guard_pkg::OP_PAT_WRITE, s1, p, 1'b0);
		@(negedge clock);
		check8(train_data, p);
		train_phase = 1'b1;
		@(negedge clock);
		check1(train_drive, 1'b1);
		train_phase = 1'b0;
		@(negedge clock);
		check1(train_drive, 1'b0);
		rd(guard_pkg::OP_PAT_READ, s1, p);
		wr(guard_pkg::OP_PAT_STORE, s1, q, 1'b0);
		strobe(1'b1);
		@(negedge clock);
		check8(train_data, q);
		$display("Test pattern done");
		for (int t = 0; t < 4; t++) gate_cfg(t, 1'b0);
		wr(guard_pkg::OP_LATCH_SET, s1, 8'h00, 1'b0);
		check1(config_latch, 1'b1);
		for (int t = 0; t < 4; t++) gate_cfg(t, 1'b1);
		strobe(1'b1);
		rd(guard_pkg::OP_LOCK_READ, s1, lock_byte(1'b1, 1'b1));
		$display("Test latch done");
		wr(guard_pkg::OP_LOCK_CLEAR, s1, 8'h00, 1'b0);
		check1(guard_array_lock, 1'b0);
		wr(guard_pkg::OP_NV_PROG, s1, 8'h00, 1'b1);
		wr(guard_pkg::OP_NV_ERASE, s1, 8'h00, 1'b1);
		rd(guard_pkg::OP_NV_READ, s1, 8'hFF);
		strobe(1'b0);
		rd(guard_pkg::OP_LOCK_READ, s1, lock_byte(1'b1, 1'b0));
		$display("Test lock done");
		foreach (modes[i]) begin
			hw_reset(modes[i]);
			check1(guard_array_lock, modes[i] != 2'h1);
			check1(config_latch, 1'b0);
			check8(train_data, q);
		end
		strobe(1'b0);
		check1(guard_array_lock, 1'b1);
		wr(guard_pkg::OP_NV_PROG, s2, 8'h00, 1'b0);
		rd(guard_pkg::OP_NV_READ, s2, 8'h00);
		$display("Test modes done");
		report_and_stop();
	end
endmodule : test_sector_protect_lock_regs
